// [src/tpcd_cfg.svh]
// Contract
// [RULE1] jumper removed selects level control; jumper fitted selects edge control.
// [RULE2] in edge mode only a falling input is a command, decoded with other levels.
// [RULE3] stop falling with both unlock inputs high locks both directions.
// [RULE4] unlock a falling alone opens a once; closes on 5 s, passage or lock.
// [RULE5] unlock b falling alone opens b once; closes on 5 s, passage or lock.
// [RULE6] an unlock falling while the other unlock is low opens both once.
// [RULE7] unlock a falling with stop low, or stop falling with a low, frees a.
// [RULE8] unlock b falling with stop low, or stop falling with b low, frees b.
// [RULE9] any falling input while the other two are low frees both directions.
// [RULE10] the panel holds an input low while its button is pressed.
// [RULE11] level mode closes both when both unlocks are high or stop is low.
// [RULE12] level mode opens a while unlock a is low and others are high.
// [RULE13] level mode opens b while unlock b is low and others are high.
// [RULE14] level mode opens both while both unlocks are low and stop is high.
// [RULE15] the controller shows low by closed relay, high by open relay.
// [RULE16] control inputs are synchronised and debounced before edge detection.
// [RULE17] a passage-done pulse per direction ends a single-passage state.
`ifndef TPCD_CFG_SVH
`define TPCD_CFG_SVH

`define TPCD_CLK_HZ          125000000
`define TPCD_SINGLE_S        5
`define TPCD_SINGLE_CYCLES   (`TPCD_SINGLE_S * `TPCD_CLK_HZ)
`define TPCD_DEBOUNCE_US     10000
`define TPCD_DEBOUNCE_CYCLES (`TPCD_DEBOUNCE_US * (`TPCD_CLK_HZ / 1000000))
`define TPCD_INPUTS_IDLE     3'h7
`define TPCD_DIR_A           0
`define TPCD_DIR_B           1

`endif

// [src/tpcd_pkg.sv]
package tpcd_pkg;

	// active-low control contacts, released level is high
	typedef struct packed {
		logic unlock_a_n;
		logic stop_n;
		logic unlock_b_n;
	} tpcd_ctrl_t;

	// one bit per passage direction
	typedef struct packed {
		logic dir_b;
		logic dir_a;
	} tpcd_pass_t;

	typedef enum logic [1:0] {
		TPCD_LOCKED,
		TPCD_SINGLE,
		TPCD_FREE
	} tpcd_dir_state_t;

endpackage : tpcd_pkg

// [src/tpcd_debounce.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tpcd_cfg.svh"
module tpcd_debounce
	import tpcd_pkg::*;
#(
	parameter int unsigned CYCLES = `TPCD_DEBOUNCE_CYCLES
) (
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire tpcd_ctrl_t raw,
	output var  tpcd_ctrl_t clean
);

	localparam logic [31:0] LAST = 32'(CYCLES - 1);

	logic [2:0]  raw_v;
	logic [2:0]  sync1_q;
	logic [2:0]  sync2_q;
	logic [2:0]  stable_q;
	logic [31:0] cnt_q [3];

	assign raw_v = raw;
	assign clean = stable_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	////////////////////////////////////////////////////////////////////////////
	// per contact: two-stage synchroniser, then a stability counter
	for (genvar i = 0; i < 3; i++) begin : g_bit
		logic        diff;
		logic        hit;
		assign diff = sync2_q[i] ^ stable_q[i];
		assign hit  = diff && (cnt_q[i] == LAST);

		always_ff @(posedge clk) begin
			if (!reset_n) begin
				sync1_q[i]  <= 1'b1;
				sync2_q[i]  <= 1'b1;
				stable_q[i] <= 1'b1;
				cnt_q[i]    <= 32'h0;
			end else begin
				sync1_q[i]  <= raw_v[i];
				sync2_q[i]  <= sync1_q[i]; // RULE16
				stable_q[i] <= hit ? sync2_q[i] : stable_q[i];
				cnt_q[i]    <= (diff && !hit) ? cnt_q[i] + 32'h1 : 32'h0; // RULE16
			end
		end

		deb_settle_a: assert property ($changed(stable_q[i]) |-> $past(cnt_q[i]) == LAST) // RULE16
			else $error("debounced level changed before the input settled");
	end

endmodule : tpcd_debounce
`default_nettype wire

// [src/tpcd_decoder.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tpcd_cfg.svh"
module tpcd_decoder
	import tpcd_pkg::*;
#(
	parameter int unsigned SINGLE_CYCLES   = `TPCD_SINGLE_CYCLES,
	parameter int unsigned DEBOUNCE_CYCLES = `TPCD_DEBOUNCE_CYCLES
) (
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire tpcd_ctrl_t control_input_terminal,
	input  wire logic       mode_jumper,
	input  wire tpcd_pass_t passage_done,
	output var  tpcd_pass_t passage_open_q,
	output var  tpcd_pass_t passage_free_q
);

	localparam logic [31:0] SINGLE_LAST = 32'(SINGLE_CYCLES - 1);

	tpcd_ctrl_t      dbc;
	logic [2:0]      dbc_v;
	logic [2:0]      prev_q;
	logic [2:0]      fall;
	logic            la;
	logic            ls;
	logic            lb;
	logic            f_a;
	logic            f_s;
	logic            f_b;
	logic            sel_a;
	logic            sel_s;
	logic            sel_b;
	logic            pulse_mode;
	logic            cmd_lock;
	logic [1:0]      cmd_single;
	logic [1:0]      cmd_free;
	logic [1:0]      done_v;
	logic            both_closed;
	logic [1:0]      pot_open;
	logic [1:0]      open_d;
	logic [1:0]      free_d;
	tpcd_dir_state_t st_q   [2];
	tpcd_dir_state_t st_d   [2];
	logic [31:0]     tmr_q  [2];
	logic [31:0]     tmr_d  [2];

	////////////////////////////////////////////////////////////////////////////
	// input conditioning; panel and controller hold a contact low while active
	tpcd_debounce #(
		.CYCLES (DEBOUNCE_CYCLES)
	) u_debounce (
		.clk     (clk),
		.reset_n (reset_n),
		.raw     (control_input_terminal),
		.clean   (dbc)
	);

	// edge detector runs on the debounced levels only
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			prev_q <= `TPCD_INPUTS_IDLE;
		end else begin
			prev_q <= dbc_v;
		end
	end

	assign dbc_v = dbc;
	assign fall  = prev_q & ~dbc_v; // RULE2
	assign f_a   = fall[2];
	assign f_s   = fall[1];
	assign f_b   = fall[0];
	assign la    = dbc.unlock_a_n;
	assign ls    = dbc.stop_n;
	assign lb    = dbc.unlock_b_n;

	////////////////////////////////////////////////////////////////////////////
	// edge-mode command decode; coincident edges resolve stop, then a, then b
	assign pulse_mode = mode_jumper; // RULE1
	assign sel_s      = f_s;
	assign sel_a      = f_a && !f_s;
	assign sel_b      = f_b && !f_s && !f_a;

	assign cmd_lock      = pulse_mode && sel_s && la && lb; // RULE3
	assign cmd_single[0] = pulse_mode && ls && (sel_a || (sel_b && !la)); // RULE4 RULE6
	assign cmd_single[1] = pulse_mode && ls && (sel_b || (sel_a && !lb)); // RULE5 RULE6
	assign cmd_free[0]   = pulse_mode && ((sel_s && !la) || (sel_a && !ls) || (sel_b && !ls && !la)); // RULE7 RULE9
	assign cmd_free[1]   = pulse_mode && ((sel_s && !lb) || (sel_b && !ls) || (sel_a && !ls && !lb)); // RULE8 RULE9
	assign done_v        = passage_done; // RULE17

	// level-mode decode, both-closed overrides any open request
	assign both_closed = (la && lb) || !ls; // RULE11
	assign pot_open[0] = !both_closed && !la; // RULE12 RULE14
	assign pot_open[1] = !both_closed && !lb; // RULE13 RULE14

	////////////////////////////////////////////////////////////////////////////
	// per-direction passage state with single-passage timer
	for (genvar d = 0; d < 2; d++) begin : g_dir
		logic timed_out;
		assign timed_out = tmr_q[d] == SINGLE_LAST;

		// lock beats free, free beats single; a new command beats passage or timeout
		always_comb begin
			st_d[d]  = st_q[d];
			tmr_d[d] = tmr_q[d];
			if (!pulse_mode) begin
				st_d[d]  = TPCD_LOCKED;
				tmr_d[d] = 32'h0;
			end else if (cmd_lock) begin
				st_d[d]  = TPCD_LOCKED; // RULE3
				tmr_d[d] = 32'h0;
			end else if (cmd_free[d]) begin
				st_d[d]  = TPCD_FREE; // RULE7 RULE8 RULE9
				tmr_d[d] = 32'h0;
			end else if (cmd_single[d] && st_q[d] != TPCD_FREE) begin
				st_d[d]  = TPCD_SINGLE; // RULE4 RULE5 RULE6
				tmr_d[d] = 32'h0;
			end else begin
				case (st_q[d])
					TPCD_SINGLE: begin
						if (done_v[d] || timed_out) begin
							st_d[d]  = TPCD_LOCKED; // RULE4 RULE5 RULE17
							tmr_d[d] = 32'h0;
						end else begin
							tmr_d[d] = tmr_q[d] + 32'h1;
						end
					end
					TPCD_LOCKED,
					TPCD_FREE: begin
						tmr_d[d] = 32'h0;
					end
					default: begin
						st_d[d]  = TPCD_LOCKED;
						tmr_d[d] = 32'h0;
					end
				endcase
			end
		end

		always_ff @(posedge clk) begin
			if (!reset_n) begin
				st_q[d]  <= TPCD_LOCKED;
				tmr_q[d] <= 32'h0;
			end else begin
				st_q[d]  <= st_d[d];
				tmr_q[d] <= tmr_d[d];
			end
		end

		assign open_d[d] = pulse_mode ? (st_d[d] != TPCD_LOCKED) : pot_open[d]; // RULE1
		assign free_d[d] = pulse_mode && (st_d[d] == TPCD_FREE);
	end

	// registered release outputs toward the arm drive
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			passage_open_q <= '0;
			passage_free_q <= '0;
		end else begin
			passage_open_q <= open_d;
			passage_free_q <= free_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	no_edge_cmd_a: assert property (fall == 3'h0 |-> !cmd_lock && cmd_single == 2'h0 && cmd_free == 2'h0) // RULE2
		else $error("command decoded without a falling edge");

	lock_both_a: assert property (pulse_mode && f_s && la && lb // RULE3
		|=> st_q[0] == TPCD_LOCKED && st_q[1] == TPCD_LOCKED && !passage_open_q.dir_a && !passage_open_q.dir_b)
		else $error("stop edge did not lock both directions");

	// b may still end its own single passage in that cycle, which is not a change made by the command
	single_a_a: assert property (pulse_mode && f_a && !f_s && ls && lb && st_q[0] != TPCD_FREE // RULE4
		&& !(st_q[1] == TPCD_SINGLE && (passage_done.dir_b || tmr_q[1] == SINGLE_LAST))
		|=> st_q[0] == TPCD_SINGLE && tmr_q[0] == 32'h0 && st_q[1] == $past(st_q[1]))
		else $error("unlock a edge did not start a single passage in a");

	single_b_a: assert property (pulse_mode && f_b && !f_s && !f_a && ls && la && st_q[1] != TPCD_FREE // RULE5
		|=> st_q[1] == TPCD_SINGLE && passage_open_q.dir_b)
		else $error("unlock b edge did not start a single passage in b");

	single_both_a: assert property (pulse_mode && f_a && !f_s && ls && !lb |-> cmd_single == 2'h3 && cmd_free == 2'h0) // RULE6
		else $error("unlock edge with other unlock low did not open both once");

	single_keep_free_a: assert property (st_q[0] == TPCD_FREE && !cmd_lock && pulse_mode |=> st_q[0] == TPCD_FREE) // RULE6
		else $error("free direction was changed by a single command");

	free_a_a: assert property (pulse_mode && ((f_s && !la && lb) || (f_a && !f_s && !ls && lb)) // RULE7
		&& !(st_q[1] == TPCD_SINGLE && (passage_done.dir_b || tmr_q[1] == SINGLE_LAST))
		|=> st_q[0] == TPCD_FREE && passage_free_q.dir_a && st_q[1] == $past(st_q[1]))
		else $error("free passage in a not set");

	free_b_a: assert property (pulse_mode && ((f_s && !lb && la) || (f_b && !f_s && !f_a && !ls && la)) // RULE8
		|=> st_q[1] == TPCD_FREE && passage_free_q.dir_b)
		else $error("free passage in b not set");

	free_both_a: assert property (pulse_mode && f_s && !la && !lb |=> passage_free_q == 2'h3) // RULE9
		else $error("free passage in both directions not set");

	// the output closes at the same edge as the state; a later command may reopen it
	timeout_a_a: assert property (pulse_mode && st_q[0] == TPCD_SINGLE && tmr_q[0] == SINGLE_LAST // RULE4
		&& !cmd_free[0] && !cmd_single[0] |=> st_q[0] == TPCD_LOCKED && !passage_open_q.dir_a)
		else $error("single passage in a outlived its timeout");

	passage_end_a: assert property (pulse_mode && st_q[1] == TPCD_SINGLE && passage_done.dir_b // RULE17
		&& !cmd_free[1] && !cmd_single[1] |=> st_q[1] == TPCD_LOCKED)
		else $error("passage in b did not end the single passage");

	pot_closed_a: assert property (!pulse_mode && ((la && lb) || !ls) |=> passage_open_q == 2'h0) // RULE11
		else $error("level mode did not close both directions");

	pot_open_a_a: assert property (!pulse_mode && !la && ls && lb |=> passage_open_q == 2'h1) // RULE12
		else $error("level mode did not open only a");

	pot_open_b_a: assert property (!pulse_mode && !lb && ls && la |=> passage_open_q == 2'h2) // RULE13
		else $error("level mode did not open only b");

	pot_open_both_a: assert property (!pulse_mode && !la && !lb && ls |=> passage_open_q == 2'h3) // RULE14
		else $error("level mode did not open both directions");

	pot_no_state_a: assert property (!pulse_mode |=> st_q[0] == TPCD_LOCKED && st_q[1] == TPCD_LOCKED) // RULE1
		else $error("edge-mode state kept while in level mode");

	single_timeout_c: cover property (st_q[0] == TPCD_SINGLE && tmr_q[0] == SINGLE_LAST ##1 st_q[0] == TPCD_LOCKED);
	single_passed_c:  cover property (st_q[1] == TPCD_SINGLE && passage_done.dir_b ##1 st_q[1] == TPCD_LOCKED);
	free_both_c:      cover property (passage_free_q == 2'h3 ##1 cmd_lock);
	pot_both_c:       cover property (!pulse_mode && passage_open_q == 2'h3);

endmodule : tpcd_decoder
`default_nettype wire

// [tb/tpcd_panel.sv]
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// remote panel: one button per contact, a set bit means the button is held
module tpcd_panel
	import tpcd_pkg::*;
(
	input  wire logic       clk,
	input  wire tpcd_ctrl_t pressed,
	output var  tpcd_ctrl_t contacts
);
	// held button closes the contact to ground, released one floats to the pull-up
	always @(posedge clk) begin
		contacts <= ~pressed;
	end
endmodule : tpcd_panel
`default_nettype wire

// [tb/turnstile_passage_command_decoder_bench.sv]
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module turnstile_passage_command_decoder_bench;
	import tpcd_pkg::*;
	localparam int unsigned SINGLE = 40;
	localparam int unsigned DEB    = 4;
	localparam int unsigned W      = 14;
	localparam logic [2:0]  BA     = 3'h4;
	localparam logic [2:0]  BS     = 3'h2;
	localparam logic [2:0]  BB     = 3'h1;
	logic        clk          = 1'b0;
	logic        reset_n      = 1'b0;
	logic        mode_jumper  = 1'b1;
	tpcd_ctrl_t  pressed      = '0;
	tpcd_pass_t  passage_done = '0;
	tpcd_ctrl_t  contacts;
	tpcd_pass_t  open_q;
	tpcd_pass_t  free_q;
	logic        sample       = 1'b0;
	logic [3:0]  exp_q[$];
	logic [31:0] rng          = 32'h4c;
	int          miscompares  = 0;
	int          num_checks   = 0;

	// 8 ns clock
	always #4 clk = ~clk;

	tpcd_panel panel_u (
		.clk      (clk),
		.pressed  (pressed),
		.contacts (contacts)
	);

	tpcd_decoder #(.SINGLE_CYCLES(SINGLE), .DEBOUNCE_CYCLES(DEB)) dut_u (
		.clk                    (clk),
		.reset_n                (reset_n),
		.control_input_terminal (contacts),
		.mode_jumper            (mode_jumper),
		.passage_done           (passage_done),
		.passage_open_q         (open_q),
		.passage_free_q         (free_q)
	);

	////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xorshift

	task automatic check(input logic [3:0] seen, input logic [3:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: outputs %b expected %b", $time, seen, exp);
		end
	endtask : check

	task automatic end_of_test();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : end_of_test

	// hold the buttons, note {open b, open a, free b, free a}, let it settle
	task automatic step(input logic [2:0] btn, input logic [3:0] exp, input int unsigned n);
		@(posedge clk);
		pressed <= btn;
		exp_q.push_back(exp);
		repeat (n) @(posedge clk);
		sample <= 1'b1;
		@(posedge clk);
		sample <= 1'b0;
	endtask : step

	task automatic done(input tpcd_pass_t d);
		@(posedge clk);
		passage_done <= d;
		@(posedge clk);
		passage_done <= '0;
	endtask : done

	// monitor takes the oldest note whenever a result is due
	always @(negedge clk) begin
		if (sample) begin
			check({open_q, free_q}, exp_q.pop_front());
		end
	end

	// watchdog
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		end_of_test();
	end

	////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [2:0] btn;
		int         len;
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		step(3'h0, 4'h0, W);
		step(BA, 4'h4, W);
		step(3'h0, 4'h0, SINGLE);
		step(BB, 4'h8, W);
		done(2'h2);
		step(3'h0, 4'h0, 4);
		// short glitch of random length must not reach the decoder
		rng = xorshift(rng);
		len = 1 + int'(rng[0]);
		@(posedge clk);
		pressed <= BA;
		repeat (len) @(posedge clk);
		pressed <= 3'h0;
		step(3'h0, 4'h0, W);
		step(BB, 4'h8, W);
		step(BB | BA, 4'hc, W);
		step(3'h0, 4'hc, 2);
		step(BS, 4'h0, W);
		step(BS | BA, 4'h5, W);
		step(3'h0, 4'h5, 2);
		step(BB, 4'hd, W);
		step(3'h0, 4'h5, SINGLE);
		step(BA, 4'h5, W);
		done(2'h1);
		step(3'h0, 4'h5, 4);
		step(BS, 4'h0, W);
		step(BB, 4'h8, W);
		step(BB | BS, 4'ha, W);
		step(3'h0, 4'ha, 2);
		step(BS, 4'h0, W);
		step(BA, 4'h4, W);
		step(BA | BS, 4'h5, W);
		step(BS, 4'h5, 2);
		step(BS | BB, 4'hf, W);
		step(3'h0, 4'hf, 2);
		step(BS, 4'h0, W);
		step(BA, 4'h4, W);
		step(BA | BB, 4'hc, W);
		step(BA | BB | BS, 4'hf, W);
		step(3'h0, 4'hf, 2);
		step(BS, 4'h0, W);
		step(3'h0, 4'h0, 2);
		// level mode: every combination, then random ones
		@(posedge clk);
		mode_jumper <= 1'b0;
		step(3'h0, 4'h0, W);
		for (int i = 0; i < 16; i++) begin
			rng = xorshift(rng);
			btn = (i < 8) ? 3'(i) : rng[2:0];
			step(btn, btn[1] ? 4'h0 : {btn[0], btn[2], 2'h0}, W);
		end
		end_of_test();
	end
endmodule : turnstile_passage_command_decoder_bench
`default_nettype wire
